/* File: logic/plc_mac_header_framer.sv */
`timescale 1ns/1ps
// Function
// R1: Transmit priority must be 0..2; other values are rejected.
// R2: Segment control bytes inserted on transmit and expected on receive.
// R3: Frame pending bit is always sent as zero.
// R4: Two frame version bits are always written as zero.
// R5: Auxiliary security header is absent or exactly 6 bytes.
// R6: Ack request bit is converted to the physical delimiter type.
// R7: Ack request and delimiter type must never disagree.
// R8: Ack frame type is never generated nor accepted.
// R9: Sync indication only reports identifier conflict or realignment.
// R10: No path exists to request pending data from a coordinator.
// R11: Other fields follow the standard order; FCS appended on transmit and checked.
module plc_mac_header_framer #(
   parameter int ADDR_BYTES = 8
) (
   input wire logic mclk,
   input wire logic reset,
   // Transmit request from upper layer
   input wire logic tx_start,
   input wire logic [1:0] tx_priority_level,
   input wire logic [2:0] tx_frame_type,
   input wire logic tx_security,
   input wire logic tx_ack_request,
   input wire logic tx_pan_compress,
   input wire logic [1:0] tx_dst_mode,
   input wire logic [1:0] tx_src_mode,
   input wire logic [7:0] tx_seq,
   input wire logic [3:0] tx_aux_len,
   input wire logic [23:0] tx_seg_ctrl,
   output logic tx_busy,
   output logic tx_reject,
   // Payload byte stream in (accepted once FC, segment control and sequence are loaded)
   input wire logic tx_pl_valid,
   input wire logic [7:0] tx_pl_data,
   input wire logic tx_pl_last,
   output logic tx_pl_ready,
   // To physical layer
   output logic phy_valid,
   output logic [7:0] phy_data,
   output logic phy_last,
   input wire logic phy_ready,
   output logic [2:0] phy_delimiter_type,
   output logic [1:0] phy_priority,
   // Receive header check (first bytes of a received frame)
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic rx_last,
   input wire logic rx_delim_ack,
   output logic rx_hdr_ok,
   output logic rx_hdr_err,
   output logic rx_fcs_ok,
   output logic rx_done,
   // Upper layer notifications
   input wire logic pan_conflict,
   input wire logic pan_realign,
   output logic sync_ind,
   output logic [1:0] sync_reason
);
   typedef enum {S_IDLE, S_FC0, S_FC1, S_SEG, S_SEQ, S_PAY, S_FCS0, S_FCS1, S_DONE} tx_state_e;
   tx_state_e tx_state;
   logic [15:0] fc;
   logic [7:0] seq;
   logic [23:0] seg;
   logic [1:0] seg_idx;
   logic [15:0] tx_crc;
   logic [15:0] rx_crc;
   logic [1:0] prio;
   logic ack_req;

   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] r;
      r = c;
      for (int i = 0; i < 8; i++) begin
         if (r[0] ^ d[i]) begin
            r = (r >> 1) ^ mac_hdr_pkg::FCS_POLY_REFL;
         end else begin
            r = r >> 1;
         end
      end
      return r;
   endfunction : crc_step

   wire prio_ok = tx_priority_level <= mac_hdr_pkg::PRIO_CFREE; // [R1]
   wire aux_ok = (tx_aux_len == 4'h0) || (tx_aux_len == 4'(mac_hdr_pkg::AUX_SEC_LEN)); // [R5]
   wire type_ok = tx_frame_type != mac_hdr_pkg::FT_ACK; // [R8]
   wire sec_ok = tx_security == (tx_aux_len != 4'h0); // [R5]
   wire tx_accept = tx_start && !tx_busy && prio_ok && aux_ok && type_ok && sec_ok;
   wire phy_fire = phy_valid && phy_ready;
   // State advances on load, not on hand-off, so no byte is sent twice
   wire out_free = !phy_valid || phy_ready;
   wire hdr_load = out_free && (tx_state inside {S_FC0, S_FC1, S_SEG, S_SEQ, S_FCS0, S_FCS1});
   wire pl_load = tx_pl_valid && tx_pl_ready;
   wire byte_load = hdr_load || pl_load;

   assign tx_busy = tx_state != S_IDLE;
   assign tx_pl_ready = (tx_state == S_PAY) && out_free;

   // Request check; rejected frames never start
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         tx_reject <= 1'b0;
      end else begin
         tx_reject <= tx_start && !tx_busy && !(prio_ok && aux_ok && type_ok && sec_ok); // [R1] [R5] [R8]
      end
   end

   // Latch header fields
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         fc <= 16'h0000;
         seq <= 8'h00;
         seg <= 24'h000000;
         prio <= mac_hdr_pkg::PRIO_NORMAL;
         ack_req <= 1'b0;
      end else if (tx_accept) begin
         fc <= 16'h0000;
         fc[mac_hdr_pkg::FC_TYPE_LSB +: 3] <= tx_frame_type;
         fc[mac_hdr_pkg::FC_SEC_BIT] <= tx_security;
         fc[mac_hdr_pkg::FC_PEND_BIT] <= mac_hdr_pkg::FC_PEND_VAL; // [R3] [R10]
         fc[mac_hdr_pkg::FC_ACKREQ_BIT] <= tx_ack_request;
         fc[mac_hdr_pkg::FC_PANC_BIT] <= tx_pan_compress;
         fc[mac_hdr_pkg::FC_DAM_LSB +: 2] <= tx_dst_mode;
         fc[mac_hdr_pkg::FC_VER_LSB +: 2] <= mac_hdr_pkg::FC_VER_VAL; // [R4]
         fc[mac_hdr_pkg::FC_SAM_LSB +: 2] <= tx_src_mode;
         seq <= tx_seq;
         seg <= tx_seg_ctrl;
         prio <= tx_priority_level;
         ack_req <= tx_ack_request;
      end
   end

   // Delimiter type follows the same latched ack bit as the header
   assign phy_delimiter_type = ack_req ? mac_hdr_pkg::DELIM_ACKREQ : mac_hdr_pkg::DELIM_NOACK; // [R6] [R7]
   assign phy_priority = prio; // [R1]

   // Transmit sequencer: FC, segment control, sequence, rest from upper layer, FCS
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         tx_state <= S_IDLE;
         seg_idx <= 2'h0;
      end else begin
         case (tx_state)
            S_IDLE: begin
               if (tx_accept) begin
                  tx_state <= S_FC0;
               end
            end
            S_FC0: begin
               if (hdr_load) begin
                  tx_state <= S_FC1;
               end
            end
            S_FC1: begin
               if (hdr_load) begin
                  tx_state <= S_SEG;
                  seg_idx <= 2'h0;
               end
            end
            S_SEG: begin
               if (hdr_load) begin
                  if (seg_idx == 2'(mac_hdr_pkg::SEG_CTRL_LEN - 1)) begin
                     tx_state <= S_SEQ;
                  end
                  seg_idx <= seg_idx + 2'h1;
               end
            end
            S_SEQ: begin
               if (hdr_load) begin
                  tx_state <= S_PAY;
               end
            end
            S_PAY: begin
               if (pl_load && tx_pl_last) begin
                  tx_state <= S_FCS0;
               end
            end
            S_FCS0: begin
               if (hdr_load) begin
                  tx_state <= S_FCS1;
               end
            end
            S_FCS1: begin
               if (hdr_load) begin
                  tx_state <= S_DONE;
               end
            end
            // Busy holds until the last byte has left the output register
            S_DONE: begin
               if (phy_fire) begin
                  tx_state <= S_IDLE;
               end
            end
            default: tx_state <= S_IDLE;
         endcase
      end
   end

   // Output byte register
   logic [7:0] next_byte;
   always_comb begin
      case (tx_state)
         S_FC0: next_byte = fc[7:0];
         S_FC1: next_byte = fc[15:8];
         S_SEG: next_byte = seg[8*seg_idx +: 8]; // [R2]
         S_SEQ: next_byte = seq;
         S_PAY: next_byte = tx_pl_data;
         S_FCS0: next_byte = tx_crc[7:0]; // [R11]
         S_FCS1: next_byte = tx_crc[15:8]; // [R11]
         default: next_byte = 8'h00;
      endcase
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         phy_valid <= 1'b0;
         phy_data <= 8'h00;
         phy_last <= 1'b0;
      end else if (byte_load) begin
         phy_valid <= 1'b1;
         phy_data <= next_byte;
         phy_last <= tx_state == S_FCS1;
      end else if (phy_ready) begin
         phy_valid <= 1'b0;
         phy_last <= 1'b0;
      end
   end

   // Summed as each byte is loaded, so the FCS states see the finished value
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         tx_crc <= mac_hdr_pkg::FCS_INIT;
      end else if (tx_accept) begin
         tx_crc <= mac_hdr_pkg::FCS_INIT;
      end else if (byte_load && tx_state inside {S_FC0, S_FC1, S_SEG, S_SEQ, S_PAY}) begin
         tx_crc <= crc_step(tx_crc, next_byte); // [R11]
      end
   end

   // Receive header check: frame control, then segment control bytes counted
   logic [4:0] rx_cnt;
   logic [7:0] rx_fc0;
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         rx_cnt <= 5'h00;
         rx_fc0 <= 8'h00;
         rx_hdr_ok <= 1'b0;
         rx_hdr_err <= 1'b0;
         rx_crc <= mac_hdr_pkg::FCS_INIT;
         rx_fcs_ok <= 1'b0;
         rx_done <= 1'b0;
      end else begin
         rx_hdr_ok <= 1'b0;
         rx_hdr_err <= 1'b0;
         rx_done <= 1'b0;
         if (rx_valid) begin
            rx_crc <= rx_last ? mac_hdr_pkg::FCS_INIT : crc_step(rx_crc, rx_data);
            rx_cnt <= rx_last ? 5'h00 : ((rx_cnt == 5'h1f) ? rx_cnt : rx_cnt + 5'h01);
            if (rx_cnt == 5'h00) begin
               rx_fc0 <= rx_data;
            end
            // Header judged once FC and all segment control bytes have arrived
            if (rx_cnt == 5'(1 + mac_hdr_pkg::SEG_CTRL_LEN) && !rx_last) begin // [R2]
               if (rx_fc0[mac_hdr_pkg::FC_TYPE_LSB +: 3] == mac_hdr_pkg::FT_ACK  // [R8]
                   || rx_fc0[mac_hdr_pkg::FC_ACKREQ_BIT] != rx_delim_ack) begin // [R7]
                  rx_hdr_err <= 1'b1;
               end else begin
                  rx_hdr_ok <= 1'b1;
               end
            end
            if (rx_last) begin
               // Too short to hold FC, segment control, sequence and FCS
               rx_fcs_ok <= (crc_step(rx_crc, rx_data) == 16'h0000)
                            && rx_cnt >= 5'(mac_hdr_pkg::SEG_CTRL_LEN + 4); // [R11] [R2]
               rx_done <= 1'b1;
            end
         end
      end
   end

   // Sync indication only for identifier conflict or realignment
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         sync_ind <= 1'b0;
         sync_reason <= 2'h0;
      end else begin
         sync_ind <= pan_conflict || pan_realign; // [R9]
         sync_reason <= {pan_realign, pan_conflict}; // [R9]
      end
   end

   a_prio_reject: assert property (@(posedge mclk) disable iff (reset) // [R1]
      (tx_start && !tx_busy && tx_priority_level == 2'h3) |=> tx_reject && !tx_busy)
      else $error("bad priority not rejected");
   a_pend_zero: assert property (@(posedge mclk) disable iff (reset) // [R3]
      (phy_valid && tx_state == S_FC1 && $past(tx_state) == S_FC0) |-> !phy_data[mac_hdr_pkg::FC_PEND_BIT])
      else $error("frame pending bit set");
   a_version_zero: assert property (@(posedge mclk) disable iff (reset) // [R4]
      (phy_valid && tx_state == S_SEG && $past(tx_state) == S_FC1) |-> phy_data[5:4] == 2'h0)
      else $error("frame version nonzero");
   a_delim_match: assert property (@(posedge mclk) disable iff (reset) // [R6]
      (phy_valid && tx_state == S_FC1 && $past(tx_state) == S_FC0)
      |-> (phy_delimiter_type == mac_hdr_pkg::DELIM_ACKREQ) == phy_data[mac_hdr_pkg::FC_ACKREQ_BIT])
      else $error("delimiter type disagrees with ack bit");
   a_aux_len: assert property (@(posedge mclk) disable iff (reset) // [R5]
      (tx_start && !tx_busy && tx_aux_len != 4'h0 && tx_aux_len != 4'(mac_hdr_pkg::AUX_SEC_LEN)) |=> tx_reject)
      else $error("bad aux length accepted");
   a_no_ack_type: assert property (@(posedge mclk) disable iff (reset) // [R8]
      tx_busy |-> fc[2:0] != mac_hdr_pkg::FT_ACK)
      else $error("ack frame type transmitted");
   a_seg_inserted: assert property (@(posedge mclk) disable iff (reset) // [R2]
      (tx_state == S_FC1 && hdr_load) |=> tx_state == S_SEG && phy_data == fc[15:8])
      else $error("segment control skipped");
   a_sync_cause: assert property (@(posedge mclk) disable iff (reset) // [R9]
      sync_ind |-> $past(pan_conflict) || $past(pan_realign))
      else $error("sync indication without cause");
endmodule : plc_mac_header_framer

/* File: logic/mac_hdr_pkg.sv */
package mac_hdr_pkg;
   // Frame control field bit positions
   localparam int FC_TYPE_LSB = 0;
   localparam int FC_SEC_BIT = 3;
   localparam int FC_PEND_BIT = 4;
   localparam int FC_ACKREQ_BIT = 5;
   localparam int FC_PANC_BIT = 6;
   localparam int FC_DAM_LSB = 10;
   localparam int FC_VER_LSB = 12;
   localparam int FC_SAM_LSB = 14;
   // Frame types
   localparam logic [2:0] FT_BEACON = 3'h0;
   localparam logic [2:0] FT_DATA = 3'h1;
   localparam logic [2:0] FT_ACK = 3'h2;
   localparam logic [2:0] FT_CMD = 3'h3;
   // Priority levels
   localparam logic [1:0] PRIO_NORMAL = 2'h0;
   localparam logic [1:0] PRIO_HIGH = 2'h1;
   localparam logic [1:0] PRIO_CFREE = 2'h2;
   // Delimiter types on the physical frame control header
   localparam logic [2:0] DELIM_NOACK = 3'h0;
   localparam logic [2:0] DELIM_ACKREQ = 3'h1;
   // Fixed values
   localparam logic FC_PEND_VAL = 1'b0;
   localparam logic [1:0] FC_VER_VAL = 2'h0;
   localparam int AUX_SEC_LEN = 6;
   localparam int SEG_CTRL_LEN = 3;
   localparam logic [15:0] FCS_POLY_REFL = 16'h8408;
   localparam logic [15:0] FCS_INIT = 16'h0000;
endpackage : mac_hdr_pkg

/* File: dv/phy_sink_model.sv */
`timescale 1ns/1ps
module phy_sink_model (
   input wire logic mclk,
   input wire logic reset,
   input wire logic slow,
   input wire logic clr,
   input wire logic phy_valid,
   input wire logic [7:0] phy_data,
   input wire logic phy_last,
   output logic phy_ready
);
   logic [7:0] bytes [0:31];
   int count;
   logic saw_last;
   // Slow mode stalls every other cycle so each byte must be held
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         phy_ready <= 1'b0;
         count <= 0;
         saw_last <= 1'b0;
      end else begin
         phy_ready <= slow ? ~phy_ready : 1'b1;
         if (clr) begin
            count <= 0;
            saw_last <= 1'b0;
         end else if (phy_valid && phy_ready) begin
            bytes[count[4:0]] <= phy_data;
            count <= count + 1;
            saw_last <= phy_last;
         end
      end
   end
endmodule : phy_sink_model

/* File: dv/plc_mac_header_framer_bench.sv */
`timescale 1ns/1ps
module plc_mac_header_framer_bench;
   typedef struct packed {logic [1:0] prio; logic [2:0] ft; logic ack; logic [3:0] aux; logic rej;} row_s;
   logic mclk = 1'b0, reset = 1'b1, slow = 1'b0, clr = 1'b0;
   logic tx_start = 1'b0, tx_ack_request = 1'b0, tx_security = 1'b0, tx_pan_compress = 1'b1;
   logic [1:0] tx_priority_level = 2'h0, tx_dst_mode = 2'h2, tx_src_mode = 2'h2;
   logic [2:0] tx_frame_type = 3'h1;
   logic [7:0] tx_seq = 8'h3c, tx_pl_data = 8'ha5, rx_data = 8'h00;
   logic [3:0] tx_aux_len = 4'h0;
   logic [23:0] tx_seg_ctrl = 24'h0c0b0a;
   logic tx_pl_valid = 1'b0, tx_pl_last = 1'b1, rx_valid = 1'b0, rx_last = 1'b0, rx_delim_ack = 1'b0;
   logic pan_conflict = 1'b0, pan_realign = 1'b0;
   logic tx_busy, tx_reject, tx_pl_ready, phy_valid, phy_last, phy_ready;
   logic rx_hdr_ok, rx_hdr_err, rx_fcs_ok, rx_done, sync_ind, saw_err, saw_ok;
   logic [7:0] phy_data;
   logic [2:0] phy_delimiter_type;
   logic [1:0] phy_priority, sync_reason;
   int failures = 0, num_checks = 0;
   row_s rows [0:5];
   always #5 mclk = ~mclk;
   plc_mac_header_framer u_plc_mac_header_framer (.mclk(mclk), .reset(reset), .tx_start(tx_start),
      .tx_priority_level(tx_priority_level), .tx_frame_type(tx_frame_type), .tx_security(tx_security),
      .tx_ack_request(tx_ack_request), .tx_pan_compress(tx_pan_compress), .tx_dst_mode(tx_dst_mode),
      .tx_src_mode(tx_src_mode), .tx_seq(tx_seq), .tx_aux_len(tx_aux_len), .tx_seg_ctrl(tx_seg_ctrl),
      .tx_busy(tx_busy), .tx_reject(tx_reject), .tx_pl_valid(tx_pl_valid), .tx_pl_data(tx_pl_data),
      .tx_pl_last(tx_pl_last), .tx_pl_ready(tx_pl_ready), .phy_valid(phy_valid), .phy_data(phy_data),
      .phy_last(phy_last), .phy_ready(phy_ready), .phy_delimiter_type(phy_delimiter_type),
      .phy_priority(phy_priority), .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
      .rx_delim_ack(rx_delim_ack), .rx_hdr_ok(rx_hdr_ok), .rx_hdr_err(rx_hdr_err), .rx_fcs_ok(rx_fcs_ok),
      .rx_done(rx_done), .pan_conflict(pan_conflict), .pan_realign(pan_realign), .sync_ind(sync_ind),
      .sync_reason(sync_reason));
   phy_sink_model u_phy_sink_model (.mclk(mclk), .reset(reset), .slow(slow), .clr(clr),
      .phy_valid(phy_valid), .phy_data(phy_data), .phy_last(phy_last), .phy_ready(phy_ready));
   // Pulses are latched so a frame can be judged after it ends
   always @(posedge mclk) begin
      if (clr) begin
         saw_err <= 1'b0;
         saw_ok <= 1'b0;
      end else begin
         if (rx_hdr_err === 1'b1) saw_err <= 1'b1;
         if (rx_hdr_ok === 1'b1) saw_ok <= 1'b1;
      end
   end
   task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk_val
   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : summarize
   task automatic wait_neg(input logic want, input int which);
      int n;
      n = 0;
      do begin
         @(negedge mclk);
         n++;
      end while ((which == 0 ? tx_pl_ready : tx_busy) !== want && n < 400);
      if ((which == 0 ? tx_pl_ready : tx_busy) !== want) begin
         failures++;
         summarize();
      end
   endtask : wait_neg
   function automatic logic [15:0] crc16(input logic [15:0] c, input logic [7:0] b);
      crc16 = c ^ {8'h00, b};
      for (int i = 0; i < 8; i++) crc16 = crc16[0] ? (crc16 >> 1) ^ mac_hdr_pkg::FCS_POLY_REFL : crc16 >> 1;
   endfunction : crc16
   task automatic run_row(input row_s r);
      logic [15:0] fc;
      logic [15:0] c;
      fc = {2'h2, 2'h0, 2'h2, 3'h0, 1'b1, r.ack, 1'b0, r.aux != 4'h0, r.ft};
      @(posedge mclk);
      clr <= 1'b1;
      {tx_priority_level, tx_frame_type, tx_ack_request, tx_aux_len} <= {r.prio, r.ft, r.ack, r.aux};
      tx_security <= r.aux != 4'h0;
      tx_start <= 1'b1;
      @(posedge mclk);
      clr <= 1'b0;
      tx_start <= 1'b0;
      #1;
      chk_val("reject", r.rej, tx_reject);
      chk_val("busy", !r.rej, tx_busy);
      if (!r.rej) begin
         chk_val("delimiter", r.ack, phy_delimiter_type);
         chk_val("priority", r.prio, phy_priority);
         @(posedge mclk);
         tx_start <= 1'b1;
         tx_priority_level <= 2'h3;
         tx_pl_valid <= 1'b1;
         @(posedge mclk);
         tx_start <= 1'b0;
         #1;
         chk_val("reject while busy", 0, tx_reject);
         wait_neg(1'b1, 0);
         @(posedge mclk);
         tx_pl_valid <= 1'b0;
         wait_neg(1'b0, 1);
         repeat (2) @(negedge mclk);
         chk_val("byte count", 9, u_phy_sink_model.count);
         chk_val("last flag", 1, u_phy_sink_model.saw_last);
         chk_val("fc", fc, {u_phy_sink_model.bytes[1], u_phy_sink_model.bytes[0]});
         for (int k = 0; k < 3; k++) chk_val("segment", tx_seg_ctrl[8*k+:8], u_phy_sink_model.bytes[2+k]);
         chk_val("seq", tx_seq, u_phy_sink_model.bytes[5]);
         chk_val("payload", 8'ha5, u_phy_sink_model.bytes[6]);
         c = crc16(crc16(16'h0000, fc[7:0]), fc[15:8]);
         for (int k = 0; k < 3; k++) c = crc16(c, tx_seg_ctrl[8*k+:8]);
         c = crc16(crc16(c, tx_seq), 8'ha5);
         chk_val("fcs", c, {u_phy_sink_model.bytes[8], u_phy_sink_model.bytes[7]});
      end
   endtask : run_row
   task automatic rx_frame(input logic [2:0] ft, input logic ack, input logic dack, input logic bad,
                           input logic badfcs);
      logic [7:0] b [0:7];
      logic [15:0] c;
      {b[1], b[0]} = {8'h88, 1'b0, 1'b1, ack, 2'b00, ft};
      {b[4], b[3], b[2], b[5]} = {tx_seg_ctrl, 8'h17};
      c = 16'h0000;
      for (int k = 0; k < 6; k++) c = crc16(c, b[k]);
      {b[7], b[6]} = c;
      b[6] = b[6] ^ {7'h00, badfcs};
      @(posedge mclk);
      clr <= 1'b1;
      rx_delim_ack <= dack;
      for (int k = 0; k < 8; k++) begin
         @(posedge mclk);
         clr <= 1'b0;
         {rx_valid, rx_data, rx_last} <= {1'b1, b[k], k == 7};
      end
      @(posedge mclk);
      {rx_valid, rx_last} <= 2'b00;
      #1;
      chk_val("fcs ok", !badfcs, rx_fcs_ok);
      chk_val("rx done", 1, rx_done);
      repeat (3) @(posedge mclk);
      #1;
      chk_val("hdr err", bad, saw_err);
      chk_val("hdr ok", !bad, saw_ok);
   endtask : rx_frame
   initial begin
      rows[0] = {2'h0, 3'h1, 1'b0, 4'h0, 1'b0};
      rows[1] = {2'h1, 3'h1, 1'b1, 4'h6, 1'b0};
      rows[2] = {2'h2, 3'h3, 1'b0, 4'h0, 1'b0};
      rows[3] = {2'h3, 3'h1, 1'b0, 4'h0, 1'b1};
      rows[4] = {2'h0, 3'h1, 1'b0, 4'h4, 1'b1};
      rows[5] = {2'h0, 3'h2, 1'b0, 4'h0, 1'b1};
      repeat (3) @(posedge mclk);
      #1;
      chk_val("outputs in reset", 0, {tx_busy, phy_valid, sync_ind, rx_hdr_err});
      repeat (3) @(posedge mclk);
      reset <= 1'b0;
      foreach (rows[i]) begin
         slow <= i[0];
         run_row(rows[i]);
         $display("tx row %0d done", i);
      end
      rx_frame(3'h1, 1'b1, 1'b1, 1'b0, 1'b0);
      rx_frame(3'h1, 1'b1, 1'b0, 1'b1, 1'b0);
      rx_frame(3'h2, 1'b0, 1'b0, 1'b1, 1'b0);
      rx_frame(3'h1, 1'b0, 1'b0, 1'b0, 1'b1);
      $display("rx tests done");
      for (int k = 1; k < 4; k++) begin
         @(posedge mclk);
         {pan_realign, pan_conflict} <= k[1:0];
         @(posedge mclk);
         #1;
         chk_val("sync ind", 1, sync_ind);
         chk_val("sync reason", k[1:0], sync_reason);
      end
      @(posedge mclk);
      {pan_realign, pan_conflict} <= 2'b00;
      repeat (2) @(posedge mclk);
      #1;
      chk_val("sync idle", 0, sync_ind);
      $display("sync test done");
      summarize();
   end
endmodule : plc_mac_header_framer_bench
